//--- hw/demr_pkg.sv
package demr_pkg;
    // register byte offsets on the bus
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_EXT_ONE = 8'h04;
    localparam logic [7:0] OFS_EXT_TWO = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    localparam logic [7:0] OFS_LATENCY = 8'h10;
    // reset values
    localparam logic [2:0] CL_RST = 3'h3;
    localparam logic [12:0] EXT_ONE_RST = 13'h0000;
    localparam logic [12:0] EXT_TWO_RST = 13'h0000;
    // field positions in the first extended register
    localparam int LOOP_DISABLE_BIT = 0;
    localparam int DRIVE_REDUCE_BIT = 1;
    localparam int TERMINATION_SEL_LOW = 2;
    localparam int AL_LSB = 3;
    localparam int AL_MSB = 5;
    localparam int TERMINATION_SEL_HIGH = 6;
    localparam int CAL_LSB = 7;
    localparam int CAL_MSB = 9;
    localparam int COMPLEMENT_DISABLE_BIT = 10;
    localparam int STROBE_COPY_ENABLE_BIT = 11;
    localparam int OUTPUT_DISABLE_BIT = 12;
    // field position in the second extended register
    localparam int FAST_REFRESH_BIT = 7;
    // address bits with command meaning
    localparam int DLL_RESET_ADDR_BIT = 8;
    localparam int PRE_ALL_ADDR_BIT = 10;
    // status and latency field positions
    localparam int ST_DLL_EN = 4;
    localparam int ST_DLL_LOCK = 5;
    localparam int ST_CAL_DEF = 6;
    localparam int ST_ERR_LSB = 8;
    localparam int WL_LSB = 8;
    // sticky error flags
    localparam int ERR_BUSY_LOAD = 0;
    localparam int ERR_RSVD_BITS = 1;
    localparam int ERR_RSVD_CODE = 2;
    localparam int ERR_TERM_EARLY = 3;
    localparam int ERR_TERM_SR = 4;
    localparam int ERR_W = 5;
    // bank select codes of a load
    localparam logic [1:0] BA_MODE = 2'h0;
    localparam logic [1:0] BA_ONE = 2'h1;
    localparam logic [1:0] BA_TWO = 2'h2;
    // {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] CMD_LOAD = 4'h0;
    localparam logic [3:0] CMD_REFRESH = 4'h1;
    localparam logic [3:0] CMD_PRECHARGE = 4'h2;
    localparam logic [3:0] CMD_ACTIVATE = 4'h3;
    localparam logic [3:0] CMD_WRITE = 4'h4;
    localparam logic [3:0] CMD_READ = 4'h5;
    // timing counts in link clocks
    localparam logic [7:0] DLL_LOCK_CYC = 8'hC8;
    localparam logic [3:0] TERM_WAIT_CYC = 4'h8;
    localparam logic [2:0] AL_RSVD = 3'h7;
    localparam int AL_DEPTH = 6;
    localparam int PIN_W = 21;

    typedef struct packed {
        logic cke;
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [2:0] ba;
        logic [12:0] addr;
    } demr_pins_t;

    typedef struct packed {
        logic dll_enable;
        logic drive_reduce;
        logic strobe_diff;
        logic strobe_copy;
        logic strobe_copy_n;
        logic dq_out_en;
        logic [1:0] termination_value;
        logic termination_on;
        logic [2:0] posted_additive_delay;
        logic fast_refresh;
    } demr_io_t;

    typedef enum logic [3:0] {
        DEMR_IDLE = 4'h1,
        DEMR_ACT = 4'h2,
        DEMR_PDN = 4'h4,
        DEMR_SR = 4'h8
    } demr_state_t;
endpackage : demr_pkg

//--- hw/demr_sync.sv
`timescale 1ns/10ps
module demr_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // asynchronous in, synchronous out
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // first stage feeds only the second
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= d_i;
            sync_q <= meta_q;
        end
    end

    assign q_o = sync_q;
endmodule : demr_sync

//--- hw/demr_al_delay.sv
`timescale 1ns/10ps
module demr_al_delay (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // link edge strobe and commands
    input wire logic step_i,
    input wire logic rd_i,
    input wire logic wr_i,
    input wire logic [2:0] al_i,
    // delayed commands, valid with step_i
    output logic rd_o,
    output logic wr_o
);
    import demr_pkg::*;

    logic [AL_DEPTH-1:0] rd_q;
    logic [AL_DEPTH-1:0] wr_q;
    logic [2:0] tap_w;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_q <= '0;
            wr_q <= '0;
        end else if (step_i) begin
            rd_q <= {rd_q[AL_DEPTH-2:0], rd_i};
            wr_q <= {wr_q[AL_DEPTH-2:0], wr_i};
        end
    end

    // reserved delay code behaves as the longest one
    assign tap_w = (al_i > 3'(AL_DEPTH)) ? 3'(AL_DEPTH - 1) : al_i - 3'h1;
    assign rd_o = (al_i == 3'h0) ? rd_i : rd_q[tap_w];
    assign wr_o = (al_i == 3'h0) ? wr_i : wr_q[tap_w];
endmodule : demr_al_delay

//--- hw/demr_top.sv
`timescale 1ns/10ps
module demr_top (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // memory side pins
    input wire logic mem_clk_i,
    input wire logic termination_control_i,
    input wire demr_pkg::demr_pins_t pins_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    // decoded controls
    output demr_pkg::demr_io_t io_o,
    output logic [3:0] read_latency_o,
    output logic [3:0] write_latency_o,
    output logic dll_locked_o,
    output logic rd_issue_o,
    output logic wr_issue_o
);
    import demr_pkg::*;
    // synchronised pins
    logic [PIN_W+1:0] sync_w;
    logic mclk_s;
    logic term_s;
    demr_pins_t pin_s;
    demr_sync #(.W(PIN_W + 2)) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i({mem_clk_i, termination_control_i, pins_i}),
        .q_o(sync_w)
    );
    assign mclk_s = sync_w[PIN_W+1];
    assign term_s = sync_w[PIN_W];
    assign pin_s = demr_pins_t'(sync_w[PIN_W-1:0]);
    // registers
    logic mclk_prev_q;
    logic cke_prev_q;
    logic [7:0] bank_open_q;
    logic [7:0] bank_open_d;
    demr_state_t state_q;
    demr_state_t state_d;
    logic [12:0] ext_one_q;
    logic [12:0] ext_two_q;
    logic [2:0] cl_q;
    logic [7:0] lock_cnt_q;
    logic [7:0] lock_cnt_d;
    logic [3:0] term_wait_q;
    logic [3:0] term_wait_d;
    logic [ERR_W-1:0] err_q;
    logic [ERR_W-1:0] err_d;
    demr_io_t io_q;
    demr_io_t io_d;
    logic [3:0] rl_q;
    logic [3:0] wl_q;
    logic locked_q;
    logic rd_iss_q;
    logic wr_iss_q;
    logic ack_q;
    logic err_ack_q;
    logic [31:0] dat_q;
    // command decode at a rising link edge
    logic edge_w;
    logic [3:0] cmd_w;
    logic is_load;
    logic ld_one;
    logic ld_two;
    logic ld_dll_rst;
    logic is_act;
    logic is_pre;
    logic is_rd;
    logic is_wr;
    logic sr_entry;
    logic pd_entry;
    logic cke_exit;
    logic banks_busy;
    assign edge_w = mclk_s & ~mclk_prev_q;
    assign cmd_w = {pin_s.cs_n, pin_s.ras_n, pin_s.cas_n, pin_s.we_n};
    assign is_load = edge_w & cke_prev_q & pin_s.cke & (cmd_w == CMD_LOAD);
    assign ld_one = is_load & (pin_s.ba[1:0] == BA_ONE);
    assign ld_two = is_load & (pin_s.ba[1:0] == BA_TWO);
    assign ld_dll_rst = is_load & (pin_s.ba[1:0] == BA_MODE) & pin_s.addr[DLL_RESET_ADDR_BIT];
    assign is_act = edge_w & pin_s.cke & (cmd_w == CMD_ACTIVATE);
    assign is_pre = edge_w & pin_s.cke & (cmd_w == CMD_PRECHARGE);
    assign is_rd = edge_w & pin_s.cke & (cmd_w == CMD_READ);
    assign is_wr = edge_w & pin_s.cke & (cmd_w == CMD_WRITE);
    assign sr_entry = edge_w & cke_prev_q & ~pin_s.cke & (cmd_w == CMD_REFRESH);
    assign pd_entry = edge_w & cke_prev_q & ~pin_s.cke & (cmd_w != CMD_REFRESH);
    assign cke_exit = edge_w & ~cke_prev_q & pin_s.cke;
    // open rows stand in for bursts in flight too
    assign banks_busy = |bank_open_q;
    // bank tracking
    always_comb begin
        bank_open_d = bank_open_q;
        if (is_act) begin
            bank_open_d[pin_s.ba] = 1'b1;
        end else if (is_pre & pin_s.addr[PRE_ALL_ADDR_BIT]) begin
            bank_open_d = '0;
        end else if (is_pre) begin
            bank_open_d[pin_s.ba] = 1'b0;
        end
    end

    // power state
    always_comb begin
        state_d = state_q;
        case (state_q)
            DEMR_IDLE: begin
                if (sr_entry) begin
                    state_d = DEMR_SR;
                end else if (pd_entry) begin
                    state_d = DEMR_PDN;
                end else if (is_act) begin
                    state_d = DEMR_ACT;
                end
            end
            DEMR_ACT: begin
                if (pd_entry) begin
                    state_d = DEMR_PDN;
                end else if (~|bank_open_d) begin
                    state_d = DEMR_IDLE;
                end
            end
            DEMR_PDN: begin
                if (cke_exit) begin
                    state_d = banks_busy ? DEMR_ACT : DEMR_IDLE;
                end
            end
            DEMR_SR: begin
                if (cke_exit) begin
                    state_d = DEMR_IDLE;
                end
            end
            default: begin
                state_d = DEMR_IDLE;
            end
        endcase
    end

    // loop lock counting, in link clocks
    logic dll_en_w;
    logic dll_restart;
    assign dll_en_w = ~ext_one_q[LOOP_DISABLE_BIT] & (state_q != DEMR_SR);
    assign dll_restart = ld_dll_rst | (cke_exit & (state_q == DEMR_SR));
    always_comb begin
        lock_cnt_d = lock_cnt_q;
        if (~dll_en_w | dll_restart) begin
            lock_cnt_d = '0;
        end else if (edge_w & (lock_cnt_q != DLL_LOCK_CYC)) begin
            lock_cnt_d = lock_cnt_q + 8'h01;
        end
    end

    // termination gating
    logic [1:0] term_code_w;
    logic [1:0] new_code_w;
    logic term_state_ok;
    assign term_code_w = {ext_one_q[TERMINATION_SEL_HIGH], ext_one_q[TERMINATION_SEL_LOW]};
    assign new_code_w = {pin_s.addr[TERMINATION_SEL_HIGH], pin_s.addr[TERMINATION_SEL_LOW]};
    assign term_state_ok = (state_q == DEMR_ACT) | (state_q == DEMR_PDN);
    always_comb begin
        term_wait_d = term_wait_q;
        if (ld_one & (new_code_w != 2'h0)) begin
            term_wait_d = TERM_WAIT_CYC;
        end else if (edge_w & (term_wait_q != 4'h0)) begin
            term_wait_d = term_wait_q - 4'h1;
        end
    end

    // sticky errors, hardware set beats software clear
    logic [ERR_W-1:0] err_set;
    logic [ERR_W-1:0] err_clr;
    logic rsvd_two;
    assign rsvd_two = |(pin_s.addr & ~(13'h1 << FAST_REFRESH_BIT));
    assign err_set[ERR_BUSY_LOAD] = (ld_one | ld_two) & banks_busy;
    assign err_set[ERR_RSVD_BITS] = ((ld_one | ld_two) & pin_s.ba[2]) | (ld_two & rsvd_two);
    assign err_set[ERR_RSVD_CODE] = ld_one & (pin_s.addr[AL_MSB:AL_LSB] == AL_RSVD);
    assign err_set[ERR_TERM_EARLY] = edge_w & term_s & (term_wait_q != 4'h0);
    assign err_set[ERR_TERM_SR] = sr_entry & term_s;
    assign err_d = (err_q & ~err_clr) | err_set;
    // decoded controls from the first register, fast refresh from the second
    logic out_dis_w;
    assign out_dis_w = ext_one_q[OUTPUT_DISABLE_BIT];
    assign io_d.dll_enable = dll_en_w;
    assign io_d.drive_reduce = ext_one_q[DRIVE_REDUCE_BIT];
    assign io_d.strobe_diff = ~ext_one_q[COMPLEMENT_DISABLE_BIT] & ~out_dis_w;
    // copy ball follows its enable bit, and is forced off when outputs are disabled
    assign io_d.strobe_copy = ext_one_q[STROBE_COPY_ENABLE_BIT] & ~out_dis_w;
    assign io_d.strobe_copy_n = ext_one_q[STROBE_COPY_ENABLE_BIT]
        & ~ext_one_q[COMPLEMENT_DISABLE_BIT] & ~out_dis_w;
    assign io_d.dq_out_en = ~out_dis_w;
    assign io_d.termination_value = term_code_w;
    assign io_d.termination_on = (term_code_w != 2'h0) & term_s & term_state_ok
        & (term_wait_q == 4'h0);
    assign io_d.posted_additive_delay = ext_one_q[AL_MSB:AL_LSB];
    assign io_d.fast_refresh = ext_two_q[FAST_REFRESH_BIT];
    // held commands
    logic dly_rd;
    logic dly_wr;
    demr_al_delay u_al (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .step_i(edge_w),
        .rd_i(is_rd),
        .wr_i(is_wr),
        .al_i(ext_one_q[AL_MSB:AL_LSB]),
        .rd_o(dly_rd),
        .wr_o(dly_wr)
    );
    // bus decode
    logic acc_w;
    logic hit_w;
    logic wr_w;
    logic [31:0] rd_mux;
    assign acc_w = wb_cyc_i & wb_stb_i & ~ack_q & ~err_ack_q;
    assign hit_w = (wb_adr_i == OFS_CTRL) | (wb_adr_i == OFS_EXT_ONE)
        | (wb_adr_i == OFS_EXT_TWO) | (wb_adr_i == OFS_STATUS)
        | (wb_adr_i == OFS_LATENCY);
    assign wr_w = acc_w & wb_we_i & wb_sel_i[1];
    assign err_clr = (wr_w & (wb_adr_i == OFS_STATUS)) ? wb_dat_i[ST_ERR_LSB +: ERR_W] : '0;
    assign rd_mux = (wb_adr_i == OFS_CTRL) ? {29'h0, cl_q}
        : (wb_adr_i == OFS_EXT_ONE) ? {19'h0, ext_one_q}
        : (wb_adr_i == OFS_EXT_TWO) ? {19'h0, ext_two_q}
        : (wb_adr_i == OFS_STATUS) ? {19'h0, err_q, 1'b0,
            &ext_one_q[CAL_MSB:CAL_LSB], locked_q, io_q.dll_enable, state_q}
        : (wb_adr_i == OFS_LATENCY) ? {20'h0, wl_q, 4'h0, rl_q}
        : 32'h0;
    // link-side state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mclk_prev_q <= 1'b0;
            cke_prev_q <= 1'b0;
            bank_open_q <= '0;
            state_q <= DEMR_IDLE;
            lock_cnt_q <= '0;
            term_wait_q <= '0;
        end else begin
            mclk_prev_q <= mclk_s;
            cke_prev_q <= edge_w ? pin_s.cke : cke_prev_q;
            bank_open_q <= bank_open_d;
            state_q <= state_d;
            lock_cnt_q <= lock_cnt_d;
            term_wait_q <= term_wait_d;
        end
    end

    // mode contents move only on a load
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext_one_q <= EXT_ONE_RST;
            ext_two_q <= EXT_TWO_RST;
        end else begin
            ext_one_q <= ld_one ? pin_s.addr : ext_one_q;
            ext_two_q <= ld_two ? pin_s.addr : ext_two_q;
        end
    end

    // decoded outputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            io_q <= '0;
            rl_q <= 4'h0;
            wl_q <= 4'h0;
            locked_q <= 1'b0;
            rd_iss_q <= 1'b0;
            wr_iss_q <= 1'b0;
        end else begin
            io_q <= io_d;
            rl_q <= {1'b0, ext_one_q[AL_MSB:AL_LSB]} + {1'b0, cl_q};
            wl_q <= {1'b0, ext_one_q[AL_MSB:AL_LSB]} + {1'b0, cl_q} - 4'h1;
            locked_q <= dll_en_w & (lock_cnt_q == DLL_LOCK_CYC);
            rd_iss_q <= edge_w & dly_rd;
            wr_iss_q <= edge_w & dly_wr;
        end
    end

    // bus slave, answers one cycle after the strobe
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            err_ack_q <= 1'b0;
            dat_q <= '0;
            cl_q <= CL_RST;
            err_q <= '0;
        end else begin
            ack_q <= acc_w & hit_w;
            err_ack_q <= acc_w & ~hit_w;
            dat_q <= (acc_w & hit_w & ~wb_we_i) ? rd_mux : dat_q;
            cl_q <= (acc_w & wb_we_i & wb_sel_i[0] & (wb_adr_i == OFS_CTRL)) ? wb_dat_i[2:0] : cl_q;
            err_q <= err_d;
        end
    end

    assign wb_dat_o = dat_q;
    assign wb_ack_o = ack_q;
    assign wb_err_o = err_ack_q;
    assign io_o = io_q;
    assign read_latency_o = rl_q;
    assign write_latency_o = wl_q;
    assign dll_locked_o = locked_q;
    assign rd_issue_o = rd_iss_q;
    assign wr_issue_o = wr_iss_q;
endmodule : demr_top

//--- tb/demr_top_sva.sv
`timescale 1ns/10ps
module demr_top_sva
    import demr_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic wb_err_o,
    // decoded controls
    input wire demr_pkg::demr_io_t io_o,
    input wire logic [3:0] read_latency_o,
    input wire logic [3:0] write_latency_o,
    input wire logic dll_locked_o,
    input wire logic rd_issue_o,
    input wire logic wr_issue_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic req;
    logic unmapped;
    logic [11:0] en_cnt_q;
    logic [11:0] en_cnt_d;
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    assign unmapped = !(wb_adr_i inside {OFS_CTRL, OFS_EXT_ONE, OFS_EXT_TWO, OFS_STATUS,
        OFS_LATENCY});
    // saturates, so a long run cannot wrap the lock check
    assign en_cnt_d = !io_o.dll_enable ? 12'h000 : en_cnt_q + {11'h000, en_cnt_q != 12'hFFF};
    always_ff @(posedge clk_i) begin
        en_cnt_q <= rst_i ? 12'h000 : en_cnt_d;
    end
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");
    ack_answer_a: assert property (req && !unmapped |=> wb_ack_o && !wb_err_o)
        else $error("no ack one cycle after request");
    err_unmapped_a: assert property (req && unmapped |=> wb_err_o && !wb_ack_o)
        else $error("unmapped access not refused");
    rdata_hold_a: assert property ($changed(wb_dat_o) |-> wb_ack_o)
        else $error("read data moved without ack");
    lat_pair_a: assert property (read_latency_o != 4'h0 |->
        write_latency_o == read_latency_o - 4'h1) else $error("write latency mismatch");
    strobe_pair_a: assert property (io_o.strobe_copy_n |->
        io_o.strobe_diff && io_o.strobe_copy) else $error("copy complement wrongly on");
    term_code_a: assert property (io_o.termination_on |->
        io_o.termination_value != 2'h0) else $error("termination on while disabled");
    issue_pulse_a: assert property (rd_issue_o || wr_issue_o |=>
        !rd_issue_o && !wr_issue_o) else $error("issue pulse too long");
    lock_dll_a: assert property (!io_o.dll_enable [*2] |-> !dll_locked_o)
        else $error("locked with loop off");
    lock_time_a: assert property ($rose(dll_locked_o) |-> en_cnt_q >= 12'h758)
        else $error("lock came too early");
    cover property (wb_err_o);
    cover property ($rose(dll_locked_o));
    cover property (rd_issue_o);
    cover property (io_o.termination_on);
endmodule : demr_top_sva

//--- tb/demr_ctrl_model.sv
`timescale 1ns/10ps
module demr_ctrl_model
    import demr_pkg::*;
(
    // bench clock
    input wire logic clk_i,
    // memory side
    output logic mem_clk_o,
    output demr_pkg::demr_pins_t pins_o
);
    initial begin
        mem_clk_o = 1'b0;
        pins_o = {1'b1, 4'hF, 3'h0, 13'h0000};
        #3;
        forever #24 mem_clk_o = ~mem_clk_o;
    end
    // pins move mid-period so both setup and hold sides get half a link clock
    task automatic cmd(input logic [3:0] c, input logic [2:0] ba, input logic [12:0] a,
        input logic cke);
        @(negedge mem_clk_o);
        @(posedge clk_i);
        pins_o <= {cke, c, ba, a};
        @(negedge mem_clk_o);
        @(posedge clk_i);
        // deselected bus shows no stale address
        pins_o <= {cke, 4'hF, ~ba, ~a};
        repeat (2) @(posedge mem_clk_o);
    endtask : cmd
endmodule : demr_ctrl_model

//--- tb/tb_demr_top.sv
`timescale 1ns/10ps
module tb_demr_top;
    import demr_pkg::*;
    localparam logic [12:0] EXT_VEC [12] = '{13'h0001, 13'h0002, 13'h0004, 13'h0040,
        13'h0044, 13'h0400, 13'h0800, 13'h0C00, 13'h1000, 13'h0380, 13'h0018, 13'h0000};
    logic clk_i;
    logic rst_i;
    logic mem_clk;
    logic term;
    demr_pins_t pins;
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic ack;
    logic err;
    demr_io_t io;
    logic [3:0] rl;
    logic [3:0] wl;
    logic locked;
    logic rd_iss;
    logic wr_iss;
    logic [31:0] q;
    logic e;
    logic f2;
    int bad_count;
    int samples_checked;
    demr_ctrl_model u_m (.clk_i(clk_i), .mem_clk_o(mem_clk), .pins_o(pins));
    demr_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .mem_clk_i(mem_clk),
        .termination_control_i(term), .pins_i(pins), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .wb_err_o(err), .io_o(io), .read_latency_o(rl),
        .write_latency_o(wl), .dll_locked_o(locked), .rd_issue_o(rd_iss),
        .wr_issue_o(wr_iss));
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string nm);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic give_verdict;
        $display("compares %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : give_verdict
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && err !== 1'b1 && n < 40);
        if (n >= 40) bad_count++;
        q = rdat;
        e = err;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    function automatic demr_io_t exp_io(input logic [12:0] v);
        demr_io_t x;
        x = '0;
        x.dll_enable = ~v[0];
        x.drive_reduce = v[1];
        x.strobe_diff = ~v[10] & ~v[12];
        x.strobe_copy = v[11] & ~v[12];
        x.strobe_copy_n = v[11] & ~v[10] & ~v[12];
        x.dq_out_en = ~v[12];
        x.termination_value = {v[6], v[2]};
        x.posted_additive_delay = v[5:3];
        x.fast_refresh = f2;
        return x;
    endfunction : exp_io
    task automatic issue(input logic [3:0] c, input int al);
        time t0;
        int n;
        u_m.cmd(CMD_LOAD, {1'b0, BA_ONE}, 13'(al << 3), 1'b1);
        chk({24'h0, rl, wl}, {24'h0, 4'(al + 4), 4'(al + 3)}, "latency");
        u_m.cmd(CMD_ACTIVATE, 3'h0, 13'h0000, 1'b1);
        fork
            u_m.cmd(c, 3'h0, 13'h0000, 1'b1);
            begin
                @(posedge mem_clk iff pins.cs_n === 1'b0);
                t0 = $time;
                n = 0;
                while ((c == CMD_READ ? rd_iss : wr_iss) !== 1'b1 && n < 200) begin
                    @(posedge clk_i);
                    n++;
                end
                chk({31'h0, $time - t0 >= al * 48 + 10 && $time - t0 <= al * 48 + 40},
                    32'h1, "issue delay");
            end
        join
        u_m.cmd(CMD_PRECHARGE, 3'h0, 13'h0400, 1'b1);
    endtask : issue
    initial begin
        rst_i = 1'b1;
        {cyc, stb, we, adr, wdat, f2} = '0;
        term = 1'b0;
        bad_count = 0;
        samples_checked = 0;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk(32'(io), 32'(exp_io(13'h0000)), "reset io");
        wb(1'b0, OFS_CTRL, 32'h0);
        chk(q, 32'h3, "ctrl reset");
        foreach (EXT_VEC[i]) begin
            u_m.cmd(CMD_LOAD, {1'b0, BA_ONE}, EXT_VEC[i], 1'b1);
            wb(1'b0, OFS_EXT_ONE, 32'h0);
            chk(q, 32'(EXT_VEC[i]), "ext one");
            chk(32'(io), 32'(exp_io(EXT_VEC[i])), "decode");
            wb(1'b0, OFS_STATUS, 32'h0);
            chk({31'h0, q[ST_CAL_DEF]}, {31'h0, &EXT_VEC[i][9:7]}, "cal default");
        end
        wb(1'b1, OFS_EXT_ONE, 32'h1FFF);
        u_m.cmd(CMD_LOAD, 3'h3, 13'h0FFF, 1'b1);
        wb(1'b0, OFS_EXT_ONE, 32'h0);
        chk(q, 32'h0, "ext one kept");
        wb(1'b0, 8'h14, 32'h0);
        chk({31'h0, e}, 32'h1, "unmapped");
        u_m.cmd(CMD_LOAD, {1'b0, BA_TWO}, 13'h0080, 1'b1);
        f2 = 1'b1;
        wb(1'b0, OFS_EXT_TWO, 32'h0);
        chk(q, 32'h80, "ext two");
        chk({31'h0, io.fast_refresh}, 32'h1, "fast refresh");
        wb(1'b1, OFS_CTRL, 32'h4);
        repeat (200) @(posedge mem_clk);
        for (int al = 0; al < 7; al++) begin
            issue(CMD_READ, al);
            issue(CMD_WRITE, al);
        end
        u_m.cmd(CMD_LOAD, {1'b0, BA_ONE}, 13'h0004, 1'b1);
        repeat (8) @(posedge mem_clk);
        @(posedge clk_i) term <= 1'b1;
        repeat (20) @(posedge clk_i);
        chk({31'h0, io.termination_on}, 32'h0, "term idle");
        u_m.cmd(CMD_ACTIVATE, 3'h0, 13'h0000, 1'b1);
        chk({31'h0, io.termination_on}, 32'h1, "term active");
        @(posedge clk_i) term <= 1'b0;
        u_m.cmd(CMD_PRECHARGE, 3'h0, 13'h0400, 1'b1);
        u_m.cmd(CMD_LOAD, {1'b0, BA_MODE}, 13'h0100, 1'b1);
        repeat (193) @(posedge mem_clk);
        chk({31'h0, locked}, 32'h0, "lock early");
        repeat (10) @(posedge mem_clk);
        chk({31'h0, locked}, 32'h1, "lock done");
        u_m.cmd(CMD_REFRESH, 3'h0, 13'h0000, 1'b0);
        wb(1'b0, OFS_STATUS, 32'h0);
        chk({26'h0, q[5:0]}, 32'h08, "self refresh");
        u_m.cmd(4'hF, 3'h0, 13'h0000, 1'b1);
        wb(1'b0, OFS_STATUS, 32'h0);
        chk({26'h0, q[5:0]}, 32'h11, "refresh exit");
        u_m.cmd(4'hF, 3'h0, 13'h0000, 1'b0);
        wb(1'b0, OFS_STATUS, 32'h0);
        chk({26'h0, q[5:0]}, 32'h14, "power down");
        u_m.cmd(4'hF, 3'h0, 13'h0000, 1'b1);
        u_m.cmd(CMD_LOAD, {1'b0, BA_ONE}, 13'h0038, 1'b1);
        wb(1'b0, OFS_STATUS, 32'h0);
        chk({27'h0, q[12:8]}, 32'h04, "reserved code flag");
        wb(1'b1, OFS_STATUS, 32'h1F00);
        wb(1'b0, OFS_STATUS, 32'h0);
        chk({27'h0, q[12:8]}, 32'h0, "flag cleared");
        give_verdict();
    end
    // whole sequence is near 6500 cycles; this leaves ample slack
    initial begin
        #400000;
        bad_count++;
        give_verdict();
    end
endmodule : tb_demr_top
bind demr_top demr_top_sva u_sva (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .wb_err_o(wb_err_o), .io_o(io_o), .read_latency_o(read_latency_o),
    .write_latency_o(write_latency_o), .dll_locked_o(dll_locked_o),
    .rd_issue_o(rd_issue_o), .wr_issue_o(wr_issue_o));
